//--- common/ipsf_regs.vh
// register offsets, field positions, reset values and widths of the sfr file
`ifndef IPSF_REGS_VH
`define IPSF_REGS_VH

// bus and memory widths
`define IPSF_ADDR_W 8
`define IPSF_DATA_W 8
`define IPSF_PTR_W 12
`define IPSF_MEM_DEPTH 4096

// register offsets on the plain register port
`define IPSF_OFS_PTR1_HIGH 8'h00
`define IPSF_OFS_PTR1_LOW 8'h01
`define IPSF_OFS_BANK_SEL 8'h02
`define IPSF_OFS_P2_PLAIN 8'h03
`define IPSF_OFS_P2_POSTINC 8'h04
`define IPSF_OFS_P2_POSTDEC 8'h05
`define IPSF_OFS_P2_PREINC 8'h06
`define IPSF_OFS_P2_OFFSET 8'h07
`define IPSF_OFS_PTR2_HIGH 8'h08
`define IPSF_OFS_PTR2_LOW 8'h09
`define IPSF_OFS_ARITH 8'h0a
`define IPSF_OFS_OFFSET_VAL 8'h0b
`define IPSF_OFS_MISC_CTRL 8'h0c
`define IPSF_OFS_STACK_STAT 8'h0d
`define IPSF_OFS_PORTE 8'h0e
`define IPSF_OFS_PORTA_HI 8'h0f

// reset values
`define IPSF_RST_HIGH4 4'h0
`define IPSF_RST_LOW8 8'h00
`define IPSF_RST_ARITH 5'h00
`define IPSF_RST_BIT 1'b0
`define IPSF_RST_PAIR 2'h0
`define IPSF_RST_TRIO 3'h0
`define IPSF_RST_ADDR 12'h000

// field positions
`define IPSF_MISC_BOR_BIT 0
`define IPSF_MISC_PLL_BIT 1
`define IPSF_STK_FULL_BIT 7
`define IPSF_STK_UNF_BIT 6
`define IPSF_PORTE_IN3_BIT 3
`define IPSF_PA_LAT_LSB 0
`define IPSF_PA_DIR_LSB 2
`define IPSF_PA_PIN_LSB 4

// brown-out configuration that leaves the soft enable usable
`define IPSF_BOR_SOFT_MODE 2'b01

`endif

//--- verilog/ipsf_sfr_file.v
// indirect pointer special function register file with pointer 2 aliases
`timescale 1ns/1ps
`include "ipsf_regs.vh"

// Contract
// - plain alias accesses memory, pointer unchanged
// - post-increment alias accesses then increments pointer
// - post-decrement alias accesses then decrements pointer
// - pre-increment alias increments then accesses
// - brownout soft enable only when config 01
// - small package unimplemented bits read zero
// - pll enable only in capable oscillator modes
// - port e bit3 read-only, needs master clear off
// - claimed port a pins six seven read zero
// - stack flags stay set until software clears
module ipsf_sfr_file (
  // clock and reset
  input wire sys_clk_in,
  input wire rst_b_in,
  // register port
  input wire [`IPSF_ADDR_W-1:0] reg_addr_in,
  input wire [`IPSF_DATA_W-1:0] reg_wdata_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  output reg [`IPSF_DATA_W-1:0] reg_rdata_out,
  // configuration levels
  input wire [1:0] brownout_config_bits_in,
  input wire master_clear_config_in,
  input wire pll_capable_osc_in,
  input wire small_package_in,
  input wire [1:0] porta_pins_six_seven_claim_in,
  // pins and stack events
  input wire porte_bit3_input_in,
  input wire [1:0] porta_pins_six_seven_in,
  input wire stack_full_set_in,
  input wire stack_underflow_set_in,
  // control outputs
  output reg brownout_soft_enable_out,
  output reg pll_enable_bit_out,
  output reg [2:0] porte_latch_out,
  output reg [1:0] porta_pins_six_seven_latch_out,
  output reg [1:0] porta_pins_six_seven_dir_out
);

  // data memory reached through the aliases
  // not reset: a byte is unknown until it is first written
  reg [`IPSF_DATA_W-1:0] data_mem [0:`IPSF_MEM_DEPTH-1];

  // pointer 1, bank select and pointer 2
  reg [3:0] pointer1_high_q;
  reg [7:0] pointer1_low_q;
  reg [3:0] bank_select_q;
  reg [`IPSF_PTR_W-1:0] pointer_two_q;
  reg [`IPSF_PTR_W-1:0] pointer_two_d;
  // arithmetic flags: negative, overflow, zero, digit carry, carry
  reg [4:0] arith_flags_q;
  // signed offset used by the offset alias
  reg [7:0] offset_val_q;
  // stored control bits, before gating by configuration
  reg brownout_soft_enable_q;
  reg pll_enable_bit_q;
  // sticky stack flags
  reg stack_full_flag_q;
  reg stack_underflow_flag_q;
  // port e latch bits and port a high pins latch and direction
  reg [2:0] porte_latch_q;
  reg [1:0] pa_latch_q;
  reg [1:0] pa_dir_q;

  // alias decode and effective address
  reg is_alias;
  reg [`IPSF_PTR_W-1:0] alias_addr;
  // register read value for non-alias locations
  reg [`IPSF_DATA_W-1:0] rd_mux;

  // configuration gates
  wire bor_allow;
  wire re3_allow;
  wire [1:0] pa_free;
  wire [`IPSF_PTR_W-1:0] offset_ext;
  wire [`IPSF_PTR_W-1:0] ptr_inc;
  wire [`IPSF_PTR_W-1:0] ptr_dec;
  wire wr_clr_stack;

  // soft enable usable only in one brown-out setting
  assign bor_allow =
    (brownout_config_bits_in == `IPSF_BOR_SOFT_MODE);
  // port e bit 3 exists only with master clear disabled
  assign re3_allow = ~master_clear_config_in;
  // a pin is free when the oscillator does not claim it
  assign pa_free = ~porta_pins_six_seven_claim_in;
  // sign-extend the offset to pointer width
  assign offset_ext = {{4{offset_val_q[7]}}, offset_val_q};
  // pointer neighbours, wrapping at the memory size
  assign ptr_inc = pointer_two_q + 12'h001;
  assign ptr_dec = pointer_two_q - 12'h001;
  // a write to the stack status register
  assign wr_clr_stack = reg_wr_in &
    (reg_addr_in == `IPSF_OFS_STACK_STAT);

  // alias decode: address used for memory and the pointer's next value
  always @* begin
    is_alias = 1'b1;
    alias_addr = pointer_two_q;
    pointer_two_d = pointer_two_q;
    case (reg_addr_in)
      `IPSF_OFS_P2_PLAIN: begin
        // pointer keeps its value
        alias_addr = pointer_two_q;
      end
      `IPSF_OFS_P2_POSTINC: begin
        // old address used, pointer steps up afterwards
        alias_addr = pointer_two_q;
        pointer_two_d = ptr_inc;
      end
      `IPSF_OFS_P2_POSTDEC: begin
        // old address used, pointer steps down afterwards
        alias_addr = pointer_two_q;
        pointer_two_d = ptr_dec;
      end
      `IPSF_OFS_P2_PREINC: begin
        // pointer steps up first, new address used
        alias_addr = ptr_inc;
        pointer_two_d = ptr_inc;
      end
      `IPSF_OFS_P2_OFFSET: begin
        // pointer plus signed offset, pointer unchanged
        alias_addr = pointer_two_q + offset_ext;
      end
      default: begin
        // not an alias location
        is_alias = 1'b0;
      end
    endcase
  end

  // read multiplexer for the stored registers
  always @* begin
    // bits not driven below read zero
    rd_mux = 8'h00;
    case (reg_addr_in)
      `IPSF_OFS_PTR1_HIGH: begin
        // pointer 1 high nibble, upper bits unimplemented
        rd_mux = {4'h0, pointer1_high_q};
      end
      `IPSF_OFS_PTR1_LOW: begin
        // pointer 1 low byte
        rd_mux = pointer1_low_q;
      end
      `IPSF_OFS_BANK_SEL: begin
        // bank number, upper bits unimplemented
        rd_mux = {4'h0, bank_select_q};
      end
      `IPSF_OFS_PTR2_HIGH: begin
        // pointer 2 high nibble as it stands after any step
        rd_mux = {4'h0, pointer_two_q[11:8]};
      end
      `IPSF_OFS_PTR2_LOW: begin
        // pointer 2 low byte
        rd_mux = pointer_two_q[7:0];
      end
      `IPSF_OFS_ARITH: begin
        // five flags, top three bits unimplemented
        rd_mux = {3'h0, arith_flags_q};
      end
      `IPSF_OFS_OFFSET_VAL: begin
        // signed offset of the offset alias
        rd_mux = offset_val_q;
      end
      `IPSF_OFS_MISC_CTRL: begin
        // disabled enables read as zero, the stored bit stays hidden
        rd_mux[`IPSF_MISC_BOR_BIT] =
          brownout_soft_enable_q & bor_allow;
        rd_mux[`IPSF_MISC_PLL_BIT] =
          pll_enable_bit_q & pll_capable_osc_in;
      end
      `IPSF_OFS_STACK_STAT: begin
        // sticky flags only, the stack level lives elsewhere
        rd_mux[`IPSF_STK_FULL_BIT] = stack_full_flag_q;
        rd_mux[`IPSF_STK_UNF_BIT] = stack_underflow_flag_q;
      end
      `IPSF_OFS_PORTE: begin
        // latch bits absent on the small package
        rd_mux[2:0] = small_package_in ? 3'h0 : porte_latch_q;
        // the pin level shows only while master clear is off
        rd_mux[`IPSF_PORTE_IN3_BIT] =
          porte_bit3_input_in & re3_allow;
      end
      `IPSF_OFS_PORTA_HI: begin
        // claimed pins read zero in all three fields
        rd_mux[`IPSF_PA_LAT_LSB +: 2] = pa_latch_q & pa_free;
        rd_mux[`IPSF_PA_DIR_LSB +: 2] = pa_dir_q & pa_free;
        rd_mux[`IPSF_PA_PIN_LSB +: 2] =
          porta_pins_six_seven_in & pa_free;
      end
      default: begin
        // unmapped locations and aliases read zero here
        rd_mux = 8'h00;
      end
    endcase
  end

  // alias memory access: no storage of its own, routed to data memory
  always @(posedge sys_clk_in) begin
    if (reg_wr_in && is_alias) begin
      data_mem[alias_addr] <= reg_wdata_in;
    end
  end

  // read data stands in the cycle after the read strobe only
  always @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      reg_rdata_out <= `IPSF_RST_LOW8;
    end else if (reg_rd_in) begin
      // rd_mux shows zero for aliases, so memory is picked here
      if (is_alias) begin
        // alias read returns memory contents
        reg_rdata_out <= data_mem[alias_addr];
      end else begin
        reg_rdata_out <= rd_mux;
      end
    end else begin
      // idle cycles show zero
      reg_rdata_out <= 8'h00;
    end
  end

  // pointer 2: moved by alias accesses or by direct writes
  always @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pointer_two_q <= `IPSF_RST_ADDR;
    end else if (reg_wr_in &&
                 reg_addr_in == `IPSF_OFS_PTR2_HIGH) begin
      // high nibble write
      pointer_two_q[11:8] <= reg_wdata_in[3:0];
    end else if (reg_wr_in &&
                 reg_addr_in == `IPSF_OFS_PTR2_LOW) begin
      // low byte write
      pointer_two_q[7:0] <= reg_wdata_in;
    end else if ((reg_wr_in || reg_rd_in) && is_alias) begin
      // direct writes above win; they never share a strobe with an alias
      // any alias access, read or write, applies its pointer step
      pointer_two_q <= pointer_two_d;
    end
  end

  // plain stored registers
  always @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pointer1_high_q <= `IPSF_RST_HIGH4;
      pointer1_low_q <= `IPSF_RST_LOW8;
      bank_select_q <= `IPSF_RST_HIGH4;
      arith_flags_q <= `IPSF_RST_ARITH;
      offset_val_q <= `IPSF_RST_LOW8;
      brownout_soft_enable_q <= `IPSF_RST_BIT;
      pll_enable_bit_q <= `IPSF_RST_BIT;
      porte_latch_q <= `IPSF_RST_TRIO;
      pa_latch_q <= `IPSF_RST_PAIR;
      pa_dir_q <= `IPSF_RST_PAIR;
    end else if (reg_wr_in) begin
      case (reg_addr_in)
        `IPSF_OFS_PTR1_HIGH: begin
          // only the low nibble is stored
          pointer1_high_q <= reg_wdata_in[3:0];
        end
        `IPSF_OFS_PTR1_LOW: begin
          // full byte
          pointer1_low_q <= reg_wdata_in;
        end
        `IPSF_OFS_BANK_SEL: begin
          // only the low nibble is stored
          bank_select_q <= reg_wdata_in[3:0];
        end
        `IPSF_OFS_ARITH: begin
          // five flag bits, the rest is dropped
          arith_flags_q <= reg_wdata_in[4:0];
        end
        `IPSF_OFS_OFFSET_VAL: begin
          // signed offset for the offset alias
          offset_val_q <= reg_wdata_in;
        end
        `IPSF_OFS_MISC_CTRL: begin
          // writes to a disabled enable are dropped
          if (bor_allow) begin
            brownout_soft_enable_q <=
              reg_wdata_in[`IPSF_MISC_BOR_BIT];
          end
          if (pll_capable_osc_in) begin
            pll_enable_bit_q <= reg_wdata_in[`IPSF_MISC_PLL_BIT];
          end
        end
        `IPSF_OFS_PORTE: begin
          // bit 3 is read-only; latches absent on small package
          if (!small_package_in) begin
            porte_latch_q <= reg_wdata_in[2:0];
          end
        end
        `IPSF_OFS_PORTA_HI: begin
          // stored even while claimed, hidden by the read gate
          pa_latch_q <= reg_wdata_in[`IPSF_PA_LAT_LSB +: 2];
          pa_dir_q <= reg_wdata_in[`IPSF_PA_DIR_LSB +: 2];
        end
        default: begin
          // other locations store nothing here
        end
      endcase
    end
  end

  // sticky stack flags: hardware set wins over a software clear
  always @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      stack_full_flag_q <= `IPSF_RST_BIT;
      stack_underflow_flag_q <= `IPSF_RST_BIT;
    end else begin
      // writing zero clears, writing one leaves the flag alone
      stack_full_flag_q <= stack_full_set_in | (stack_full_flag_q &
        ~(wr_clr_stack & ~reg_wdata_in[`IPSF_STK_FULL_BIT]));
      stack_underflow_flag_q <= stack_underflow_set_in |
        (stack_underflow_flag_q &
        ~(wr_clr_stack & ~reg_wdata_in[`IPSF_STK_UNF_BIT]));
    end
  end

  // registered control outputs, gated by the configuration
  always @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      brownout_soft_enable_out <= `IPSF_RST_BIT;
      pll_enable_bit_out <= `IPSF_RST_BIT;
      porte_latch_out <= `IPSF_RST_TRIO;
      porta_pins_six_seven_latch_out <= `IPSF_RST_PAIR;
      porta_pins_six_seven_dir_out <= `IPSF_RST_PAIR;
    end else begin
      brownout_soft_enable_out <=
        brownout_soft_enable_q & bor_allow;
      pll_enable_bit_out <= pll_enable_bit_q & pll_capable_osc_in;
      porte_latch_out <= small_package_in ? 3'h0 : porte_latch_q;
      porta_pins_six_seven_latch_out <= pa_latch_q & pa_free;
      porta_pins_six_seven_dir_out <= pa_dir_q & pa_free;
    end
  end

endmodule // ipsf_sfr_file

//--- dv/ipsf_sfr_file_properties.sv
// checker of the gating relations at the sfr file ports
`timescale 1ns/1ps
module ipsf_sfr_file_props (
  // clock and reset
  input wire sys_clk_in,
  input wire rst_b_in,
  // register port
  input wire [7:0] reg_addr_in,
  input wire reg_rd_in,
  input wire [7:0] reg_rdata_out,
  // configuration levels
  input wire [1:0] brownout_config_bits_in,
  input wire master_clear_config_in,
  input wire pll_capable_osc_in,
  input wire small_package_in,
  input wire [1:0] porta_pins_six_seven_claim_in,
  // gated outputs
  input wire brownout_soft_enable_out,
  input wire pll_enable_bit_out,
  input wire [2:0] porte_latch_out,
  input wire [1:0] porta_pins_six_seven_latch_out,
  input wire [1:0] porta_pins_six_seven_dir_out
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_b_in);
  // outputs follow the gate one cycle later
  property p_bor;
    $past(brownout_config_bits_in) != 2'b01 |-> !brownout_soft_enable_out;
  endproperty
  property p_pll;
    !$past(pll_capable_osc_in) |-> !pll_enable_bit_out;
  endproperty
  property p_small;
    $past(small_package_in) |-> porte_latch_out == 3'h0;
  endproperty
  property p_pa0;
    $past(porta_pins_six_seven_claim_in[0]) |->
      !porta_pins_six_seven_latch_out[0] && !porta_pins_six_seven_dir_out[0];
  endproperty
  property p_pa1;
    $past(porta_pins_six_seven_claim_in[1]) |->
      !porta_pins_six_seven_latch_out[1] && !porta_pins_six_seven_dir_out[1];
  endproperty
  // read data gated by the configuration at the strobe edge
  property p_rd_bor;
    $past(reg_rd_in && reg_addr_in == 8'h0c &&
      brownout_config_bits_in != 2'b01) |-> !reg_rdata_out[0];
  endproperty
  property p_rd_pin3;
    $past(reg_rd_in && reg_addr_in == 8'h0e && master_clear_config_in)
      |-> !reg_rdata_out[3];
  endproperty
  property p_rd_small;
    $past(reg_rd_in && reg_addr_in == 8'h0e && small_package_in)
      |-> reg_rdata_out[2:0] == 3'h0;
  endproperty
  property p_rd_pa;
    $past(reg_rd_in && reg_addr_in == 8'h0f &&
      porta_pins_six_seven_claim_in[0]) |->
      (reg_rdata_out & 8'h15) == 8'h00;
  endproperty
  a_bor: assert property (p_bor)
    else $error("soft enable out while gate off");
  a_pll: assert property (p_pll)
    else $error("pll enable out while gate off");
  a_small: assert property (p_small)
    else $error("port e latch out on small package");
  a_pa0: assert property (p_pa0)
    else $error("claimed pin six bits driven");
  a_pa1: assert property (p_pa1)
    else $error("claimed pin seven bits driven");
  a_rd_bor: assert property (p_rd_bor)
    else $error("soft enable read while gate off");
  a_rd_pin3: assert property (p_rd_pin3)
    else $error("pin three read with master clear on");
  a_rd_small: assert property (p_rd_small)
    else $error("port e latch read on small package");
  a_rd_pa: assert property (p_rd_pa)
    else $error("claimed pin six read not zero");
  // main scenarios reached
  c_bor: cover property (brownout_soft_enable_out);
  c_pll: cover property (pll_enable_bit_out);
  c_rd: cover property ($past(reg_rd_in) && reg_rdata_out != 8'h00);
endmodule // ipsf_sfr_file_props

bind ipsf_sfr_file ipsf_sfr_file_props i_props (
  .sys_clk_in, .rst_b_in, .reg_addr_in, .reg_rd_in, .reg_rdata_out,
  .brownout_config_bits_in, .master_clear_config_in, .pll_capable_osc_in,
  .small_package_in, .porta_pins_six_seven_claim_in,
  .brownout_soft_enable_out, .pll_enable_bit_out, .porte_latch_out,
  .porta_pins_six_seven_latch_out, .porta_pins_six_seven_dir_out
);

//--- dv/ipsf_core_model.sv
// core datapath model that masters the register port
`timescale 1ns/1ps
module ipsf_core_model (
  // clock
  input wire sys_clk_in,
  // register port
  output logic [7:0] reg_addr_out,
  output logic [7:0] reg_wdata_out,
  output logic reg_wr_out,
  output logic reg_rd_out,
  input wire [7:0] reg_rdata_in
);
  // idle bus at time zero
  initial begin
    reg_addr_out = 8'h00;
    reg_wdata_out = 8'h00;
    reg_wr_out = 1'b0;
    reg_rd_out = 1'b0;
  end
  // one write cycle, entered right after a rising edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr_out <= a;
    reg_wdata_out <= d;
    reg_wr_out <= 1'b1;
    @(posedge sys_clk_in);
    reg_wr_out <= 1'b0;
    reg_wdata_out <= ~d;
    @(posedge sys_clk_in);
  endtask
  // one read cycle; data taken at the edge closing the cycle after it
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    reg_addr_out <= a;
    reg_rd_out <= 1'b1;
    @(posedge sys_clk_in);
    reg_rd_out <= 1'b0;
    @(posedge sys_clk_in);
    d = reg_rdata_in;
  endtask
endmodule // ipsf_core_model

//--- dv/testbench.sv
// self-checking bench of the sfr file against a memory and pointer model
`timescale 1ns/1ps
module testbench;
  // clock, reset and level inputs
  logic sys_clk_in, rst_b_in;
  logic [1:0] brownout_config_bits_in, porta_pins_six_seven_claim_in;
  logic master_clear_config_in, pll_capable_osc_in, small_package_in;
  logic porte_bit3_input_in, stack_full_set_in, stack_underflow_set_in;
  logic [1:0] porta_pins_six_seven_in;
  // register port, driven by the core model
  wire [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out;
  wire reg_wr_in, reg_rd_in;
  // design outputs
  wire brownout_soft_enable_out, pll_enable_bit_out;
  wire [2:0] porte_latch_out;
  wire [1:0] porta_pins_six_seven_latch_out, porta_pins_six_seven_dir_out;
  // model: bytes written so far and pointer 2
  logic [7:0] mem [int];
  logic [7:0] got;
  logic [7:0] rz [10] = '{0, 1, 2, 8, 9, 10, 11, 12, 13, 8'h20};
  int p, ofs, k, error_cnt, n_compared;
  int cyc = 0;

  ipsf_sfr_file i_dut (.*);
  ipsf_core_model i_core (
    .sys_clk_in, .reg_addr_out(reg_addr_in), .reg_wdata_out(reg_wdata_in),
    .reg_wr_out(reg_wr_in), .reg_rd_out(reg_rd_in),
    .reg_rdata_in(reg_rdata_out)
  );

  // 100 mhz clock
  initial begin
    sys_clk_in = 1'b0;
    forever #5 sys_clk_in = ~sys_clk_in;
  end
  // byte compare
  task automatic cmp(input string n, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      error_cnt++;
    end
  endtask
  // register read compare
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    i_core.rd(a, got);
    cmp("rdata", e, got);
  endtask
  // one alias access; the model picks the address and steps the pointer
  task automatic acc(input int k, input bit w);
    int a;
    logic [7:0] d;
    a = (p + (k == 3) + (k == 4 ? ofs : 0)) & 12'hfff;
    d = $urandom;
    if (w || !mem.exists(a)) begin
      i_core.wr(8'(k + 3), d);
      mem[a] = d;
    end else begin
      i_core.rd(8'(k + 3), got);
      cmp("alias", mem[a], got);
    end
    p = (p + (k == 1 || k == 3) - (k == 2)) & 12'hfff;
  endtask
  // verdict
  task automatic report_and_stop;
    if (error_cnt == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // hang guard
  always @(posedge sys_clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      error_cnt++;
      report_and_stop();
    end
  end

  initial begin
    rst_b_in = 1'b0;
    brownout_config_bits_in = 2'b01;
    porta_pins_six_seven_claim_in = 2'b00;
    master_clear_config_in = 1'b0;
    pll_capable_osc_in = 1'b1;
    small_package_in = 1'b0;
    porte_bit3_input_in = 1'b1;
    porta_pins_six_seven_in = 2'b10;
    stack_full_set_in = 1'b0;
    stack_underflow_set_in = 1'b0;
    error_cnt = 0;
    n_compared = 0;
    k = $urandom(33777);
    repeat (16) @(posedge sys_clk_in);
    rst_b_in <= 1'b1;
    @(posedge sys_clk_in);
    // reset values, an unmapped offset, nibble-wide registers and the five-bit flags
    foreach (rz[i]) rc(rz[i], 8'h00);
    for (k = 0; k < 3; k += 2) begin
      i_core.wr(8'(k), 8'hff);
      rc(8'(k), 8'h0f);
    end
    i_core.wr(8'h0a, 8'hff);
    rc(8'h0a, 8'h1f);
    // read data stand for one cycle only, then fall back to zero
    @(posedge sys_clk_in);
    cmp("rdata_idle", 8'h00, reg_rdata_out);
    // random alias traffic around the top of memory
    p = 12'hffd;
    ofs = -2;
    i_core.wr(8'h08, 8'h0f);
    i_core.wr(8'h09, 8'hfd);
    i_core.wr(8'h0b, 8'hfe);
    repeat (80) acc($urandom_range(4), $urandom_range(1));
    rc(8'h09, p[7:0]);
    rc(8'h08, 8'(p >> 8));
    // enables under every brown-out setting
    i_core.wr(8'h0c, 8'h03);
    for (k = 0; k < 4; k++) begin
      brownout_config_bits_in <= 2'(k);
      pll_capable_osc_in <= (k == 1);
      rc(8'h0c, {6'h0, k == 1, k == 1});
      cmp("enables", {6'h0, k == 1, k == 1}, {6'h0, pll_enable_bit_out,
        brownout_soft_enable_out});
    end
    // port e pin input and small package
    i_core.wr(8'h0e, 8'h07);
    rc(8'h0e, 8'h0f);
    master_clear_config_in <= 1'b1;
    rc(8'h0e, 8'h07);
    cmp("latch", 8'h07, {5'h0, porte_latch_out});
    small_package_in <= 1'b1;
    rc(8'h0e, 8'h00);
    cmp("latch", 8'h00, {5'h0, porte_latch_out});
    // port a pins claimed one by one
    i_core.wr(8'h0f, 8'h0f);
    for (k = 0; k < 4; k++) begin
      porta_pins_six_seven_claim_in <= 2'(k);
      rc(8'h0f, 8'h2f & ~(k[0] ? 8'h15 : 8'h0) &
        ~(k[1] ? 8'h2a : 8'h0));
      cmp("porta", 8'h0f & ~(k[0] ? 8'h05 : 8'h0) & ~(k[1] ? 8'h0a : 8'h0),
        {4'h0, porta_pins_six_seven_dir_out,
        porta_pins_six_seven_latch_out});
    end
    // sticky stack flags
    stack_full_set_in <= 1'b1;
    stack_underflow_set_in <= 1'b1;
    @(posedge sys_clk_in);
    stack_full_set_in <= 1'b0;
    stack_underflow_set_in <= 1'b0;
    rc(8'h0d, 8'hc0);
    i_core.wr(8'h0d, 8'hff);
    rc(8'h0d, 8'hc0);
    i_core.wr(8'h0d, 8'h40);
    rc(8'h0d, 8'h40);
    // set and software clear in one cycle: the set wins
    fork
      i_core.wr(8'h0d, 8'h00);
      begin
        stack_full_set_in <= 1'b1;
        @(posedge sys_clk_in);
        stack_full_set_in <= 1'b0;
      end
    join
    rc(8'h0d, 8'h80);
    // reset in mid-run clears the flags and pointer 2
    rst_b_in <= 1'b0;
    repeat (2) @(posedge sys_clk_in);
    cmp("rst_rdata", 8'h00, reg_rdata_out);
    rst_b_in <= 1'b1;
    @(posedge sys_clk_in);
    rc(8'h0d, 8'h00);
    rc(8'h09, 8'h00);
    report_and_stop();
  end
endmodule // testbench
